// ### tsu_gen_ctrl.sv
// The address map and the APB register port were decided locally.
module tsu_gen_ctrl
  import tsu_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic hw_trigger,
  input wire logic low_power,
  output logic irq,
  output logic wakeup,
  output logic unit_on,
  output logic scan_active,
  output logic current_source_swap
);
  tsu_scan_if sif ();

  logic [TSU_SCANS_PER_ELECTRODE_W-1:0] nscan_r;
  logic en_r, ien_r, low_power_run_enable_r, stm_r, eos_r, current_source_swap_r;
  logic irq_stat_r, irq_mask_r;
  logic pready_r, pslverr_r, irq_r, wakeup_r, unit_on_r;
  logic [31:0] prdata_r;
  logic [31:0] gencs_rd;

  // decode
  wire setup = psel && !penable;
  wire access = psel && penable && pready_r;
  wire wr = access && pwrite;
  wire hit_gencs = paddr == TSU_GENCS_OFS;
  wire hit_start = paddr == TSU_START_OFS;
  wire hit_stat = paddr == TSU_IRQ_STAT_OFS;
  wire hit_mask = paddr == TSU_IRQ_MASK_OFS;
  wire hit_any = hit_gencs || hit_start || hit_stat || hit_mask;
  wire wr_gencs = wr && hit_gencs;
  wire wr_start = wr && hit_start;
  wire wr_stat = wr && hit_stat;
  wire wr_mask = wr && hit_mask;

  // low power stops the unit unless told to keep running
  wire run_en = en_r && (!low_power || low_power_run_enable_r);
  wire sw_trig = wr_start && pwdata[TSU_SWSTART_BIT] && !stm_r;
  wire hw_trig = hw_trigger && stm_r;
  // triggers arriving mid-scan are dropped; the sequencer only listens when idle
  wire trig = run_en && !sif.busy && (sw_trig || hw_trig);
  wire eos_clr = wr_gencs && pwdata[TSU_END_OF_SCAN_FLAG_BIT];
  wire stat_clr = wr_stat && pwdata[TSU_IRQ_EOS_BIT];
  wire irq_nxt = ien_r && irq_stat_r && irq_mask_r;
  wire [31:0] rd_nxt = hit_gencs ? gencs_rd :
                       hit_stat ? {31'h0000_0000, irq_stat_r} :
                       hit_mask ? {31'h0000_0000, irq_mask_r} : TSU_ZERO_WORD;

  assign sif.start = trig;
  assign sif.run_en = run_en;
  assign sif.nscan = nscan_r;

  tsu_scan_seq u_seq (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .sif(sif)
  );

  always_comb begin
    gencs_rd = TSU_ZERO_WORD;
    gencs_rd[TSU_SCANS_PER_ELECTRODE_MSB:TSU_SCANS_PER_ELECTRODE_LSB] = nscan_r;
    gencs_rd[TSU_EN_BIT] = en_r;
    gencs_rd[TSU_IEN_BIT] = ien_r;
    gencs_rd[TSU_LOW_POWER_RUN_ENABLE_BIT] = low_power_run_enable_r;
    gencs_rd[TSU_STM_BIT] = stm_r;
    gencs_rd[TSU_SCAN_ACTIVE_BIT] = sif.active;
    gencs_rd[TSU_END_OF_SCAN_FLAG_BIT] = eos_r;
    gencs_rd[TSU_CURRENT_SOURCE_SWAP_BIT] = current_source_swap_r;
    gencs_rd[TSU_RSVD_BIT] = 1'b0;
  end

  // control fields
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      nscan_r <= TSU_SCANS_PER_ELECTRODE_RST;
      en_r <= TSU_BIT_RST;
      ien_r <= TSU_BIT_RST;
      low_power_run_enable_r <= TSU_BIT_RST;
      stm_r <= TSU_BIT_RST;
      current_source_swap_r <= TSU_BIT_RST;
      irq_mask_r <= TSU_MASK_RST;
    end else if (clk_en) begin
      if (wr_gencs) begin
        nscan_r <= pwdata[TSU_SCANS_PER_ELECTRODE_MSB:TSU_SCANS_PER_ELECTRODE_LSB];
        en_r <= pwdata[TSU_EN_BIT];
        ien_r <= pwdata[TSU_IEN_BIT];
        low_power_run_enable_r <= pwdata[TSU_LOW_POWER_RUN_ENABLE_BIT];
        stm_r <= pwdata[TSU_STM_BIT];
        current_source_swap_r <= pwdata[TSU_CURRENT_SOURCE_SWAP_BIT];
      end
      if (wr_mask) begin
        irq_mask_r <= pwdata[TSU_IRQ_EOS_BIT];
      end
    end
  end

  // sticky flags: a completion in the clearing cycle wins
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      eos_r <= TSU_BIT_RST;
      irq_stat_r <= TSU_BIT_RST;
    end else if (clk_en) begin
      eos_r <= sif.done || (eos_r && !eos_clr);
      irq_stat_r <= sif.done || (irq_stat_r && !stat_clr);
    end
  end

  // bus slave: answer prepared in setup, zero wait states
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= TSU_ZERO_WORD;
    end else if (clk_en) begin
      pready_r <= setup;
      pslverr_r <= setup && !hit_any;
      prdata_r <= setup && !pwrite ? rd_nxt : TSU_ZERO_WORD;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_r <= 1'b0;
      wakeup_r <= 1'b0;
      unit_on_r <= 1'b0;
    end else if (clk_en) begin
      irq_r <= irq_nxt;
      wakeup_r <= irq_nxt && low_power;
      unit_on_r <= run_en;
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign irq = irq_r;
  assign wakeup = wakeup_r;
  assign unit_on = unit_on_r;
  assign scan_active = sif.active;
  assign current_source_swap = current_source_swap_r;

  property p_count_field;
    @(posedge ref_clk) disable iff (!rst_n || !clk_en)
      wr_gencs |=> gencs_rd[TSU_SCANS_PER_ELECTRODE_MSB:TSU_SCANS_PER_ELECTRODE_LSB] == $past(pwdata[TSU_SCANS_PER_ELECTRODE_MSB:TSU_SCANS_PER_ELECTRODE_LSB]);
  endproperty
  a_count_field: assert property (p_count_field) else $error("count field not stored");

  property p_disabled_idle;
    @(posedge ref_clk) disable iff (!rst_n || !clk_en)
      !en_r |=> !sif.busy && !unit_on;
  endproperty
  a_disabled_idle: assert property (p_disabled_idle) else $error("disabled unit still busy");

  property p_irq_gate;
    @(posedge ref_clk) disable iff (!rst_n || !clk_en)
      (ien_r && irq_stat_r && irq_mask_r) |=> irq;
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("enabled interrupt not raised");

  property p_irq_off;
    @(posedge ref_clk) disable iff (!rst_n || !clk_en)
      !ien_r |=> !irq;
  endproperty
  a_irq_off: assert property (p_irq_off) else $error("interrupt raised while disabled");

  property p_wake;
    @(posedge ref_clk) disable iff (!rst_n || !clk_en)
      sif.done && ien_r && irq_mask_r && low_power ##1 (ien_r && irq_mask_r && low_power)
        |=> wakeup;
  endproperty
  a_wake: assert property (p_wake) else $error("no wake on scan completion");

  property p_low_power_stop;
    @(posedge ref_clk) disable iff (!rst_n || !clk_en)
      low_power && !low_power_run_enable_r |=> !sif.busy;
  endproperty
  a_low_power_stop: assert property (p_low_power_stop) else $error("ran in low power");

  property p_hw_ignored;
    @(posedge ref_clk) disable iff (!rst_n || !clk_en)
      !stm_r && !sif.busy && hw_trigger && !sw_trig |=> !sif.busy;
  endproperty
  a_hw_ignored: assert property (p_hw_ignored) else $error("hw trigger in sw mode");

  property p_sw_start;
    @(posedge ref_clk) disable iff (!rst_n || !clk_en)
      sw_trig && run_en && !sif.busy ##1 run_en |-> sif.busy;
  endproperty
  a_sw_start: assert property (p_sw_start) else $error("software start ignored");

  property p_hw_start;
    @(posedge ref_clk) disable iff (!rst_n || !clk_en)
      hw_trig && run_en && !sif.busy ##1 run_en |-> sif.busy;
  endproperty
  a_hw_start: assert property (p_hw_start) else $error("hardware trigger ignored");

  property p_active_eos;
    @(posedge ref_clk) disable iff (!rst_n || !clk_en)
      $fell(sif.active) && run_en && $past(run_en) |-> $rose(eos_r) || sif.done || eos_r;
  endproperty
  a_active_eos: assert property (p_active_eos) else $error("scan ended without end flag");

  property p_done_both;
    @(posedge ref_clk) disable iff (!rst_n || !clk_en)
      sif.done |=> !sif.active && eos_r;
  endproperty
  a_done_both: assert property (p_done_both) else $error("end flag and active out of step");

  property p_eos_w1c;
    @(posedge ref_clk) disable iff (!rst_n || !clk_en)
      eos_r && eos_clr && !sif.done |=> !eos_r;
  endproperty
  a_eos_w1c: assert property (p_eos_w1c) else $error("end flag not cleared");

  property p_eos_w0;
    @(posedge ref_clk) disable iff (!rst_n || !clk_en)
      eos_r && wr_gencs && !pwdata[TSU_END_OF_SCAN_FLAG_BIT] |=> eos_r;
  endproperty
  a_eos_w0: assert property (p_eos_w0) else $error("zero write cleared end flag");

  property p_rsvd;
    @(posedge ref_clk) disable iff (!rst_n || !clk_en)
      pready && hit_gencs |-> !prdata[TSU_RSVD_BIT];
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bit read as one");

  c_sw_scan: cover property (@(posedge ref_clk) disable iff (!rst_n) sw_trig ##[1:400] sif.done);
  c_hw_scan: cover property (@(posedge ref_clk) disable iff (!rst_n) hw_trig ##[1:400] sif.done);
  c_clear_race: cover property (@(posedge ref_clk) disable iff (!rst_n) eos_clr && sif.done);
  c_wake: cover property (@(posedge ref_clk) disable iff (!rst_n) wakeup);
endmodule : tsu_gen_ctrl

// ### tsu_pkg.sv
package tsu_pkg;
  // register byte offsets
  localparam logic [11:0] TSU_GENCS_OFS = 12'h000;
  localparam logic [11:0] TSU_START_OFS = 12'h004;
  localparam logic [11:0] TSU_IRQ_STAT_OFS = 12'h008;
  localparam logic [11:0] TSU_IRQ_MASK_OFS = 12'h00c;

  // general control/status field positions
  localparam int TSU_SCANS_PER_ELECTRODE_MSB = 12;
  localparam int TSU_SCANS_PER_ELECTRODE_LSB = 8;
  localparam int TSU_EN_BIT = 7;
  localparam int TSU_IEN_BIT = 6;
  localparam int TSU_LOW_POWER_RUN_ENABLE_BIT = 5;
  localparam int TSU_STM_BIT = 4;
  localparam int TSU_SCAN_ACTIVE_BIT = 3;
  localparam int TSU_END_OF_SCAN_FLAG_BIT = 2;
  localparam int TSU_CURRENT_SOURCE_SWAP_BIT = 1;
  localparam int TSU_RSVD_BIT = 0;
  localparam int TSU_SWSTART_BIT = 0;
  localparam int TSU_IRQ_EOS_BIT = 0;

  localparam int TSU_SCANS_PER_ELECTRODE_W = 5;
  localparam logic [TSU_SCANS_PER_ELECTRODE_W-1:0] TSU_SCANS_PER_ELECTRODE_RST = 5'h00;
  localparam logic TSU_BIT_RST = 1'b0;
  localparam logic TSU_MASK_RST = 1'b1;
  localparam logic [31:0] TSU_ZERO_WORD = 32'h0000_0000;

  // timing: bias settle and one electrode scan, rounded up to whole cycles
  localparam int TSU_CLK_PS = 4000;
  localparam int TSU_SETTLE_NS = 100;
  localparam int TSU_SCAN_NS = 40;
  localparam int TSU_SETTLE_CYC = (TSU_SETTLE_NS * 1000 + TSU_CLK_PS - 1) / TSU_CLK_PS;
  localparam int TSU_SCAN_CYC = (TSU_SCAN_NS * 1000 + TSU_CLK_PS - 1) / TSU_CLK_PS;
  localparam int TSU_CNT_W = 8;
  localparam logic [TSU_CNT_W-1:0] TSU_SETTLE_LAST = TSU_CNT_W'(TSU_SETTLE_CYC - 1);
  localparam logic [TSU_CNT_W-1:0] TSU_SCAN_LAST = TSU_CNT_W'(TSU_SCAN_CYC - 1);
  localparam logic [TSU_CNT_W-1:0] TSU_CNT_ZERO = 8'h00;
  localparam logic [TSU_CNT_W-1:0] TSU_CNT_ONE = 8'h01;

  typedef enum logic [1:0] {TSU_IDLE, TSU_SETTLE, TSU_SCAN} tsu_seq_e;
endpackage : tsu_pkg

// ### tsu_scan_if.sv
interface tsu_scan_if;
  import tsu_pkg::*;
  logic start;
  logic run_en;
  logic [TSU_SCANS_PER_ELECTRODE_W-1:0] nscan;
  logic active;
  logic busy;
  logic done;
  modport ctl (output start, output run_en, output nscan, input active, input busy, input done);
  modport seq (input start, input run_en, input nscan, output active, output busy, output done);
endinterface : tsu_scan_if

// ### tsu_scan_seq.sv
module tsu_scan_seq
  import tsu_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  tsu_scan_if.seq sif
);
  tsu_seq_e state_r, state_nxt;
  logic [TSU_CNT_W-1:0] cyc_r, cyc_nxt;
  logic [TSU_SCANS_PER_ELECTRODE_W-1:0] scan_r, scan_nxt, nscan_r, nscan_nxt;
  logic active_r, busy_r;
  wire settle_last = cyc_r == TSU_SETTLE_LAST;
  wire scan_last = cyc_r == TSU_SCAN_LAST;
  wire final_scan = scan_r == nscan_r;
  wire done_nxt = sif.run_en && state_r == TSU_SCAN && scan_last && final_scan;

  always_comb begin
    state_nxt = state_r;
    cyc_nxt = cyc_r + TSU_CNT_ONE;
    scan_nxt = scan_r;
    nscan_nxt = nscan_r;
    unique case (state_r)
      TSU_IDLE: begin
        cyc_nxt = TSU_CNT_ZERO;
        if (sif.start) begin
          state_nxt = TSU_SETTLE;
          nscan_nxt = sif.nscan; // latched so a mid-scan write cannot cut the burst
        end
      end
      TSU_SETTLE: begin
        if (settle_last) begin
          state_nxt = TSU_SCAN;
          cyc_nxt = TSU_CNT_ZERO;
          scan_nxt = '0;
        end
      end
      TSU_SCAN: begin
        if (scan_last) begin
          cyc_nxt = TSU_CNT_ZERO;
          if (final_scan) begin
            state_nxt = TSU_IDLE;
          end else begin
            scan_nxt = scan_r + 5'h01;
          end
        end
      end
    endcase
    if (!sif.run_en) begin
      state_nxt = TSU_IDLE;
      cyc_nxt = TSU_CNT_ZERO;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= TSU_IDLE;
      cyc_r <= TSU_CNT_ZERO;
      scan_r <= '0;
      nscan_r <= TSU_SCANS_PER_ELECTRODE_RST;
      active_r <= 1'b0;
      busy_r <= 1'b0;
    end else if (clk_en) begin
      state_r <= state_nxt;
      cyc_r <= cyc_nxt;
      scan_r <= scan_nxt;
      nscan_r <= nscan_nxt;
      active_r <= state_nxt == TSU_SCAN;
      busy_r <= state_nxt != TSU_IDLE;
    end
  end

  assign sif.active = active_r;
  // unregistered so the end flag lands on the edge where active drops
  assign sif.done = done_nxt;
  assign sif.busy = busy_r;

  property p_scan_count;
    @(posedge ref_clk) disable iff (!rst_n || !clk_en)
      done_nxt |-> scan_r == nscan_r;
  endproperty
  a_scan_count: assert property (p_scan_count) else $error("burst ended on wrong scan count");

  property p_settle_first;
    @(posedge ref_clk) disable iff (!rst_n || !clk_en)
      $rose(active_r) |-> $past(state_r) == TSU_SETTLE && $past(cyc_r) == TSU_SETTLE_LAST;
  endproperty
  a_settle_first: assert property (p_settle_first) else $error("scan began before settle");
endmodule : tsu_scan_seq

// ### tsu_far_model.sv
module tsu_far_model (
  input wire logic ref_clk,
  input wire logic wakeup,
  output logic hw_trigger,
  output logic low_power
);
  timeunit 1ns;
  timeprecision 1ps;
  logic woke = 1'b0;
  initial begin
    hw_trigger = 1'b0;
    low_power = 1'b0;
  end
  // one-cycle pulse, taken at the edge the task returns on
  task automatic fire();
    @(posedge ref_clk);
    hw_trigger <= 1'b1;
    @(posedge ref_clk);
    hw_trigger <= 1'b0;
  endtask : fire
  task automatic sleep(input logic v);
    @(posedge ref_clk);
    low_power <= v;
  endtask : sleep
  // cpu leaves low power on a wake request, or when the test calls sleep with 0
  always @(posedge ref_clk) begin
    if (wakeup === 1'b1 && low_power) begin
      low_power <= 1'b0;
      woke <= 1'b1;
    end
  end
endmodule : tsu_far_model

// ### testbench.sv
module testbench import tsu_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [31:0] wd; logic [31:0] rd; logic sw; logic on;} tsu_row_s;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic clk_en = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, hw_trigger, low_power, irq, wakeup;
  logic unit_on, scan_active, current_source_swap;
  logic [31:0] q, g;
  logic e;
  int errors = 0;
  int comparisons = 0;
  int cycles = 0;
  int k;
  tsu_row_s rows[5] = '{'{32'h1f80, 32'h1f80, 1'b0, 1'b1}, '{32'hf, 32'h2, 1'b1, 1'b0},
    '{32'hffff_ffff, 32'h1ff2, 1'b1, 1'b1}, '{32'ha70, 32'ha70, 1'b0, 1'b0},
    '{32'h0, 32'h0, 1'b0, 1'b0}};
  // count, irq enable, mask
  int sc[5][3] = '{'{0, 1, 1}, '{10, 1, 1}, '{31, 1, 1}, '{0, 0, 1}, '{0, 1, 0}};

  tsu_gen_ctrl dut_u (.ref_clk, .rst_n, .clk_en, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .hw_trigger, .low_power, .irq, .wakeup,
    .unit_on, .scan_active, .current_source_swap);
  tsu_far_model far_u (.ref_clk, .wakeup, .hw_trigger, .low_power);

  initial begin
    forever #2 ref_clk = ~ref_clk;
  end

  task automatic results();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : results

  // budget is ten thousand cycles; a hang ends here
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 10000) begin
      errors++;
      $display("BAD %0t timeout", $time);
      results();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk

  // request held until pready is seen at an edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [31:0] x, input string m);
    apb(1'b0, a, 32'h0);
    chk(q, x, m);
  endtask : rd

  // 400 means the level never came
  task automatic wait_act(input logic v);
    k = 0;
    do begin
      @(posedge ref_clk);
      #1;
      k++;
    end while (scan_active !== v && k < 400);
  endtask : wait_act

  task automatic burst(input int n, input logic ie);
    wait_act(1'b1);
    chk(k, 25, "settle");
    wait_act(1'b0);
    chk(k, (n + 1) * 10, "burst length");
    @(posedge ref_clk);
    #1;
    chk(irq, ie, "irq after end");
  endtask : burst

  initial begin
    repeat (16) @(posedge ref_clk);
    chk({irq, wakeup, unit_on, scan_active, current_source_swap, pready}, 0, "rst outs");
    rst_n <= 1'b1;
    rd(TSU_GENCS_OFS, 32'h0, "gencs reset");
    rd(TSU_IRQ_STAT_OFS, 32'h0, "stat reset");
    rd(TSU_IRQ_MASK_OFS, 32'h1, "mask reset");
    rd(TSU_START_OFS, 32'h0, "start reads 0");
    rd(12'h010, 32'h0, "unmapped data");
    chk(e, 1'b1, "unmapped err");
    wr(12'h010, 32'hffff_ffff);
    chk(e, 1'b1, "unmapped wr err");
    rd(TSU_GENCS_OFS, 32'h0, "unmapped wr ignored");
    $display("test reset done");
    foreach (rows[i]) begin
      wr(TSU_GENCS_OFS, rows[i].wd);
      rd(TSU_GENCS_OFS, rows[i].rd, "gencs rw");
      chk(current_source_swap, rows[i].sw, "swap");
      chk(unit_on, rows[i].on, "unit on");
    end
    $display("test rows done");
    foreach (sc[i]) begin
      g = 32'h80 | 32'(sc[i][1] << 6) | 32'(sc[i][0] << 8);
      wr(TSU_IRQ_MASK_OFS, 32'(sc[i][2]));
      wr(TSU_GENCS_OFS, g);
      wr(TSU_START_OFS, 32'h1);
      burst(sc[i][0], 1'(sc[i][1] & sc[i][2]));
      rd(TSU_IRQ_STAT_OFS, 32'h1, "stat set");
      rd(TSU_GENCS_OFS, g | 32'h4, "eos set");
      wr(TSU_GENCS_OFS, g);
      rd(TSU_GENCS_OFS, g | 32'h4, "eos write 0");
      wr(TSU_GENCS_OFS, g | 32'h4);
      rd(TSU_GENCS_OFS, g, "eos w1c");
      wr(TSU_IRQ_STAT_OFS, 32'h1);
      @(posedge ref_clk);
      #1;
      chk(irq, 1'b0, "irq cleared");
    end
    $display("test sw scans done");
    wr(TSU_GENCS_OFS, 32'h90);
    wr(TSU_START_OFS, 32'h1);
    wait_act(1'b1);
    chk(k, 400, "sw start in hw mode");
    far_u.fire();
    burst(0, 1'b0);
    wr(TSU_GENCS_OFS, 32'h94);
    wr(TSU_GENCS_OFS, 32'h80);
    far_u.fire();
    wait_act(1'b1);
    chk(k, 400, "hw trigger in sw mode");
    $display("test hw trigger done");
    wr(TSU_IRQ_STAT_OFS, 32'h1);
    wr(TSU_IRQ_MASK_OFS, 32'h1);
    wr(TSU_GENCS_OFS, 32'he0);
    far_u.sleep(1'b1);
    wr(TSU_START_OFS, 32'h1);
    chk(unit_on, 1'b1, "runs in low power");
    burst(0, 1'b1);
    repeat (3) @(posedge ref_clk);
    chk(far_u.woke, 1'b1, "wake request");
    chk(low_power, 1'b0, "cpu awake");
    wr(TSU_IRQ_STAT_OFS, 32'h1);
    wr(TSU_GENCS_OFS, 32'he4);
    wr(TSU_GENCS_OFS, 32'h80);
    far_u.sleep(1'b1);
    wr(TSU_START_OFS, 32'h1);
    chk(unit_on, 1'b0, "off in low power");
    wait_act(1'b1);
    chk(k, 400, "no scan in low power");
    far_u.sleep(1'b0);
    $display("test low power done");
    results();
  end
endmodule : testbench
